// ==== core/tpp_pkg.sv ====
// Shared constants for the temperature probe protection block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package tpp_pkg;
   // Clock and timing
   localparam int CLK_HZ = 100_000_000; // System clock rate
   localparam int TRIP_DELAY_MS = 1000; // Trip qualification delay in ms
   localparam int TRIP_DELAY_CYC = CLK_HZ / 1000 * TRIP_DELAY_MS; // Cycles in delay
   localparam int NUM_CH = 16; // Probe channels
   localparam int CH_PER_MOD = 8; // Channels on one probe module
   localparam int POLL_GAP_CYC = 256; // Gap count limit; polls are 257 idle cycles apart
   // Address settings
   localparam logic [4:0] ADDR_OFF = 5'h00; // Module address setting off
   localparam logic [4:0] ADDR_MIN = 5'h10; // Lowest legal module address
   localparam logic [4:0] ADDR_MAX = 5'h17; // Highest legal module address
   // Limits in degrees
   localparam logic [7:0] LIM_MIN = 8'h01; // Lowest legal limit
   localparam logic [7:0] LIM_MAX = 8'hC8; // Highest legal limit, also reset value
   // Group codes
   typedef enum logic [1:0] {
      TPP_GRP_OFF = 2'h0,
      TPP_GRP_STATOR = 2'h1,
      TPP_GRP_BEARING = 2'h2,
      TPP_GRP_OTHER = 2'h3
   } tpp_group_e;
   // Register byte offsets
   localparam logic [7:0] REG_MOD_ADDR = 8'h00; // Module addresses
   localparam logic [7:0] REG_GROUP = 8'h04; // Group codes, 2 bits per channel
   localparam logic [7:0] REG_ALARM_LIM = 8'h08; // Alarm limits
   localparam logic [7:0] REG_TRIP_LIM = 8'h0C; // Trip limits
   localparam logic [7:0] REG_VOTE = 8'h10; // Vote enable
   localparam logic [7:0] REG_STATUS = 8'h14; // Alarms and trips
   localparam logic [7:0] REG_TEMP_BASE = 8'h20; // Channel temperatures, 16 words
   // Field positions
   localparam int FLD_MOD2_LSB = 8; // Second address in MOD_ADDR
   localparam int FLD_BEAR_LSB = 8; // Bearing limit field
   localparam int FLD_OTHER_LSB = 16; // Other-group limit field
   localparam int FLD_TRIP_LSB = 4; // Trip bits in STATUS
   localparam logic [31:0] RESET_LIMITS = 32'h00C8C8C8; // Limits reset value
   localparam logic [31:0] BAD_READ = 32'h00000000; // Unmapped read data
endpackage : tpp_pkg

// ==== core/tpp_trip_timer.sv ====
// One-second trip qualifier for one probe group.
// Assumes the over-limit level is synchronous to clock.
`timescale 1ns/100ps
module tpp_trip_timer
   import tpp_pkg::*;
#(
   parameter int DELAY_CYC = TRIP_DELAY_CYC // Qualification time in cycles
) (
   input wire logic clock, // System clock
   input wire logic reset, // Async reset, active high
   input wire logic over, // Group currently over its trip limit
   output logic trip // Group tripped, held while over
);
   logic [31:0] count_q; // Cycles the group has been over limit

   // Counts while over; any dip restarts the delay
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_q <= 32'h00000000;
      end else if (!over) begin
         count_q <= 32'h00000000;
      end else if (count_q < 32'(DELAY_CYC)) begin
         count_q <= count_q + 32'h00000001;
      end
   end

   // Fault once the full delay has elapsed
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         trip <= 1'b0;
      end else begin
         trip <= over && (count_q >= 32'(DELAY_CYC) - 32'h00000001);
      end
   end
endmodule : tpp_trip_timer

// ==== core/tpp_core.sv ====
// Temperature probe protection: polls two probe modules, groups channels, raises alarms
// and delayed trips. Assumes a Modbus master elsewhere performs each poll request and
// returns eight readings, and an Avalon-MM master with waitrequest owns the registers.
`timescale 1ns/100ps
// What this block does
// - Poll first module at address 16-23, default off
// - Sixteen channels, each with group setting
// - Off ignored; stator, bearing, other each grouped
// - Channels 1-8 module one, 9-16 module two
// - Stator alarm limit, default 200, any probe
// - Bearing alarm limit, default 200, any probe
// - Other alarm limit, default 200, any probe
// - Stator trip limit faults after one second
// - Bearing and other trip, same one-second delay
// - Voting needs two probes over trip limit
// - Single-probe group ignores voting
module tpp_core
   import tpp_pkg::*;
#(
   parameter int DELAY_CYC = TRIP_DELAY_CYC // Trip delay, shorten for simulation
) (
   input wire logic clock, // System clock
   input wire logic reset, // Async reset, active high
   input wire logic [7:0] avs_address, // Byte address
   input wire logic avs_read, // Read strobe
   input wire logic avs_write, // Write strobe
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   output logic poll_req, // Poll request to Modbus master
   output logic [4:0] poll_addr, // Module address being polled
   input wire logic poll_ack, // Poll accepted
   input wire logic poll_done, // Readings valid pulse
   input wire logic [63:0] poll_temps, // Eight readings, channel 1 of module low
   output logic [2:0] alarm, // Stator, bearing, other alarm
   output logic [2:0] trip // Stator, bearing, other trip
);
   typedef enum logic [1:0] {
      TPP_S_GAP = 2'b00,
      TPP_S_REQ = 2'b01,
      TPP_S_WAIT = 2'b11
   } tpp_state_e;

   logic [4:0] mod1_addr_q; // First module address
   logic [4:0] mod2_addr_q; // Second module address
   logic [31:0] group_q; // Group codes
   logic [31:0] alarm_lim_q; // Alarm limits
   logic [31:0] trip_lim_q; // Trip limits
   logic vote_q; // Two probe vote enable
   logic [7:0] temp_q [NUM_CH]; // Latest readings
   logic [NUM_CH-1:0] valid_q; // Reading present
   tpp_state_e state_q; // Poll state
   logic which_q; // Module now addressed
   logic [15:0] gap_q; // Idle counter
   logic ack_q; // Bus answer cycle
   logic [2:0] over_trip; // Group trip condition
   logic [2:0] over_alarm; // Group alarm condition

   // Address setting legal and not off
   function automatic logic addr_on(input logic [4:0] a);
      return (a >= ADDR_MIN) && (a <= ADDR_MAX);
   endfunction : addr_on

   // Limit clamped into its legal range
   function automatic logic [7:0] clamp_lim(input logic [7:0] v);
      if (v < LIM_MIN) return LIM_MIN;
      if (v > LIM_MAX) return LIM_MAX;
      return v;
   endfunction : clamp_lim

   // Group code of one channel
   function automatic logic [1:0] grp_of(input logic [31:0] g, input int ch);
      return g[2*ch +: 2];
   endfunction : grp_of

   // Channel slot of a temperature word, counted from the base of its window;
   // the raw address bits alone would swap the two modules' halves
   function automatic logic [3:0] temp_slot(input logic [7:0] a);
      logic [7:0] off;
      off = a - REG_TEMP_BASE;
      return off[5:2];
   endfunction : temp_slot

   // Answer every access one cycle after it appears
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // Configuration writes; illegal addresses fall back to off
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mod1_addr_q <= ADDR_OFF;
         mod2_addr_q <= ADDR_OFF;
         group_q <= 32'h00000000;
         alarm_lim_q <= RESET_LIMITS;
         trip_lim_q <= RESET_LIMITS;
         vote_q <= 1'b0;
      end else if (avs_write && ack_q) begin
         case (avs_address)
            REG_MOD_ADDR: begin
               if (avs_byteenable[0]) begin
                  mod1_addr_q <= addr_on(avs_writedata[4:0]) ? avs_writedata[4:0] : ADDR_OFF;
               end
               if (avs_byteenable[1]) begin
                  mod2_addr_q <= addr_on(avs_writedata[FLD_MOD2_LSB +: 5]) ?
                     avs_writedata[FLD_MOD2_LSB +: 5] : ADDR_OFF;
               end
            end
            // Group codes take effect on the next evaluation
            REG_GROUP: begin
               for (int b = 0; b < 4; b++) begin
                  if (avs_byteenable[b]) group_q[8*b +: 8] <= avs_writedata[8*b +: 8];
               end
            end
            REG_ALARM_LIM: begin
               for (int b = 0; b < 3; b++) begin
                  if (avs_byteenable[b]) begin
                     alarm_lim_q[8*b +: 8] <= clamp_lim(avs_writedata[8*b +: 8]);
                  end
               end
            end
            REG_TRIP_LIM: begin
               for (int b = 0; b < 3; b++) begin
                  if (avs_byteenable[b]) begin
                     trip_lim_q[8*b +: 8] <= clamp_lim(avs_writedata[8*b +: 8]);
                  end
               end
            end
            REG_VOTE: begin
               if (avs_byteenable[0]) vote_q <= avs_writedata[0];
            end
            default: begin
               // Unmapped or read-only: ignored
            end
         endcase
      end
   end

   // Read mux, registered so data stands at the accepting edge
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         if (avs_address >= REG_TEMP_BASE && avs_address < REG_TEMP_BASE + 8'h40) begin
            // Readings are whole degrees in the low byte
            avs_readdata <= {24'h000000, temp_q[temp_slot(avs_address)]};
         end else begin
            case (avs_address)
               REG_MOD_ADDR: avs_readdata <= {19'h00000, mod2_addr_q, 3'h0, mod1_addr_q};
               REG_GROUP: avs_readdata <= group_q;
               REG_ALARM_LIM: avs_readdata <= alarm_lim_q;
               REG_TRIP_LIM: avs_readdata <= trip_lim_q;
               REG_VOTE: avs_readdata <= {31'h00000000, vote_q};
               REG_STATUS: avs_readdata <= {25'h0000000, trip, 1'b0, alarm};
               default: avs_readdata <= BAD_READ;
            endcase
         end
      end
   end

   // Poll loop alternating modules, skipping one that is off
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= TPP_S_GAP;
         which_q <= 1'b0;
         gap_q <= 16'h0000;
      end else begin
         case (state_q)
            TPP_S_GAP: begin
               if (gap_q >= 16'(POLL_GAP_CYC)) begin
                  gap_q <= 16'h0000;
                  which_q <= !which_q;
                  if (addr_on(which_q ? mod1_addr_q : mod2_addr_q)) begin
                     state_q <= TPP_S_REQ;
                  end
               end else begin
                  gap_q <= gap_q + 16'h0001;
               end
            end
            TPP_S_REQ: begin
               // Address turned off mid-request: abandon
               if (!addr_on(poll_addr)) state_q <= TPP_S_GAP;
               else if (poll_ack) state_q <= TPP_S_WAIT;
            end
            TPP_S_WAIT: begin
               // A reply cannot be refused; the poll ends when it comes
               if (poll_done) state_q <= TPP_S_GAP;
            end
            default: state_q <= TPP_S_GAP;
         endcase
      end
   end

   // Request drops the moment its address goes off
   assign poll_req = (state_q == TPP_S_REQ) && addr_on(poll_addr);
   assign poll_addr = which_q ? mod2_addr_q : mod1_addr_q;

   // Store readings into the channels of the polled module
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         valid_q <= '0;
         for (int c = 0; c < NUM_CH; c++) temp_q[c] <= 8'h00;
      end else begin
         for (int c = 0; c < CH_PER_MOD; c++) begin
            if (state_q == TPP_S_WAIT && poll_done) begin
               temp_q[c + (which_q ? CH_PER_MOD : 0)] <= poll_temps[8*c +: 8];
               valid_q[c + (which_q ? CH_PER_MOD : 0)] <= 1'b1;
            end
            // Module off: its readings no longer count
            if (!addr_on(mod1_addr_q)) valid_q[c] <= 1'b0;
            if (!addr_on(mod2_addr_q)) valid_q[c + CH_PER_MOD] <= 1'b0;
         end
      end
   end

   // Group evaluation with voting
   always_comb begin
      logic [4:0] members;
      logic [4:0] hot;
      logic [7:0] alim;
      logic [7:0] tlim;
      logic other_trip;
      // Scratch values start clean so no latch is inferred
      members = 5'h00;
      hot = 5'h00;
      alim = 8'h00;
      tlim = 8'h00;
      other_trip = 1'b0;
      over_alarm = 3'b000;
      over_trip = 3'b000;
      // Group index 0 stator, 1 bearing, 2 other; its code is index plus one
      for (int g = 0; g < 3; g++) begin
         members = 5'h00;
         hot = 5'h00;
         other_trip = 1'b0;
         alim = alarm_lim_q[8*g +: 8];
         tlim = trip_lim_q[8*g +: 8];
         for (int c = 0; c < NUM_CH; c++) begin
            if (valid_q[c] && grp_of(group_q, c) == 2'(g + 1)) begin
               members = members + 5'h01;
               if (temp_q[c] >= alim) over_alarm[g] = 1'b1;
               if (temp_q[c] >= tlim) begin
                  hot = hot + 5'h01;
                  other_trip = 1'b1;
               end
            end
         end
         // Vote only where the group has more than one probe
         if (vote_q && members > 5'h01) over_trip[g] = hot >= 5'h02;
         else over_trip[g] = other_trip;
      end
   end

   // Alarms need no delay, so they follow the compare directly
   assign alarm = over_alarm;

   // One delay qualifier per group
   for (genvar g = 0; g < 3; g++) begin : g_trip
      tpp_trip_timer #(
         .DELAY_CYC(DELAY_CYC)
      ) u_timer (
         .clock(clock),
         .reset(reset),
         .over(over_trip[g]),
         .trip(trip[g])
      );
   end

   // Poll handshake
   AST_POLL_OFF: assert property (@(posedge clock) disable iff (reset)
      poll_req |-> addr_on(poll_addr))
      else $error("poll issued to an off module");
   AST_REQ_HOLD: assert property (@(posedge clock) disable iff (reset)
      poll_req && !poll_ack && $stable(poll_addr) |=> state_q != TPP_S_WAIT)
      else $error("poll advanced without ack");
   // Trip qualification, one group each
   AST_TRIP_CAUSE: assert property (@(posedge clock) disable iff (reset)
      $rose(trip[0]) |-> $past(over_trip[0]))
      else $error("stator trip without cause");
   AST_TRIP_DROP: assert property (@(posedge clock) disable iff (reset)
      !over_trip[1] |=> !trip[1])
      else $error("bearing trip held without cause");
   AST_NO_EARLY: assert property (@(posedge clock) disable iff (reset)
      $rose(over_trip[2]) |-> !trip[2] [*3])
      else $error("other trip too early");
   // A qualified trip stays while the group is still over
   AST_TRIP_HOLD: assert property (@(posedge clock) disable iff (reset)
      over_trip[0] && trip[0] |=> trip[0])
      else $error("stator trip dropped while over");
   // No assigned channel, no alarm
   AST_ALARM_OFF: assert property (@(posedge clock) disable iff (reset)
      group_q == 32'h00000000 |-> alarm == 3'b000)
      else $error("alarm from unassigned channels");
   // Voting holds back a multi-probe group's trip until two probes are hot
   AST_VOTE_ONE: assert property (@(posedge clock) disable iff (reset)
      vote_q && over_trip[0] |-> !(members_ok(0)))
      else $error("vote passed with fewer than two hot probes");
   // Exactly one wait state on every access
   AST_ANSWER: assert property (@(posedge clock) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   // Configuration never holds a value outside its legal set
   AST_ADDR_LEGAL: assert property (@(posedge clock) disable iff (reset)
      (mod1_addr_q == ADDR_OFF || addr_on(mod1_addr_q))
      && (mod2_addr_q == ADDR_OFF || addr_on(mod2_addr_q)))
      else $error("module address outside legal set");
   AST_LIM_RANGE: assert property (@(posedge clock) disable iff (reset)
      alarm_lim_q[7:0] >= LIM_MIN && alarm_lim_q[7:0] <= LIM_MAX)
      else $error("stator alarm limit out of range");
   AST_TRIP_LIM_RANGE: assert property (@(posedge clock) disable iff (reset)
      trip_lim_q[15:8] >= LIM_MIN && trip_lim_q[15:8] <= LIM_MAX)
      else $error("bearing trip limit out of range");
   // An off module leaves no live readings behind
   AST_OFF_CLEARS: assert property (@(posedge clock) disable iff (reset)
      !addr_on(mod1_addr_q) |=> valid_q[CH_PER_MOD-1:0] == 8'h00)
      else $error("readings kept from an off module");

   // True when voting group has several members but under two hot probes
   // Counted apart from the comb block so the vote check has a view of its own
   function automatic logic members_ok(input int g);
      int m;
      int h;
      m = 0;
      h = 0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (valid_q[c] && grp_of(group_q, c) == 2'(g + 1)) begin
            m++;
            if (temp_q[c] >= trip_lim_q[8*g +: 8]) h++;
         end
      end
      return (m > 1) && (h < 2);
   endfunction : members_ok
endmodule : tpp_core

// ==== test/tpp_probe_model.sv ====
// Model of the two probe modules and their Modbus master.
// Assumes one poll in flight at a time; readings come from a table that the bench fills.
`timescale 1ns/100ps
module tpp_probe_model
   import tpp_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic reset, // Async reset, active high
   input wire logic poll_req, // Poll request
   input wire logic [4:0] poll_addr, // Polled module address
   output logic poll_ack, // Request taken
   output logic poll_done, // Readings valid
   output logic [63:0] poll_temps, // Eight readings
   input wire logic [63:0] temp_tab [0:7], // Readings by address minus 16
   input wire logic [3:0] lag, // Reply delay in cycles
   input wire logic clr, // Clears the polled record
   output logic [7:0] polled // Addresses polled so far
);
   logic busy_q; // Poll in flight
   logic [3:0] cnt_q; // Reply countdown
   logic [2:0] idx_q; // Module being answered
   // Takes one request, answers after lag cycles
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         idx_q <= 3'h0;
         poll_ack <= 1'b0;
         poll_done <= 1'b0;
         poll_temps <= 64'h0;
         polled <= 8'h00;
      end else begin
         poll_ack <= 1'b0;
         poll_done <= 1'b0;
         // Data lines toggle outside the done pulse, so nothing stale can match
         poll_temps <= ~poll_temps;
         if (clr) begin
            polled <= 8'h00;
         end
         if (poll_req && !busy_q && !poll_ack) begin
            poll_ack <= 1'b1;
            busy_q <= 1'b1;
            cnt_q <= lag;
            idx_q <= poll_addr[2:0];
            polled[poll_addr[2:0]] <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == 4'h0) begin
               // Channel one of the module in the low byte
               poll_done <= 1'b1;
               poll_temps <= temp_tab[idx_q];
               busy_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 4'h1;
            end
         end
      end
   end
endmodule : tpp_probe_model

// ==== test/tpp_core_tb.sv ====
// Self-checking bench for the probe protection core.
// Assumes the core answers each bus access after one wait state and waits 257 idle cycles before each poll.
`timescale 1ns/100ps
module tpp_core_tb;
   import tpp_pkg::*;
   localparam int DLY = 20; // Shortened trip delay
   typedef struct packed {
      logic [31:0] grp; logic [7:0] t; logic vote; logic [2:0] al; logic [2:0] tr;
   } tpp_row_s;
   logic clock = 1'b0; // System clock
   logic reset = 1'b1; // Reset
   logic [7:0] avs_address = 8'h00; // Bus address
   logic avs_read = 1'b0; // Read strobe
   logic avs_write = 1'b0; // Write strobe
   logic [31:0] avs_writedata = 32'h0; // Write data
   logic [3:0] avs_byteenable = 4'hF; // All lanes
   logic [31:0] avs_readdata; // Read data
   logic avs_waitrequest; // Stall
   logic poll_req, poll_ack, poll_done; // Poll handshake
   logic [4:0] poll_addr; // Polled address
   logic [63:0] poll_temps; // Readings
   logic [2:0] alarm, trip; // Group outputs
   logic [63:0] temp_tab [0:7]; // Probe readings
   logic [3:0] lag = 4'h0; // Model reply delay
   logic clr = 1'b0; // Clear polled record
   logic [7:0] polled; // Addresses polled
   logic [31:0] rd; // Last read word
   int bad_count = 0, n_compared = 0, cyc = 0, n; // Counters
   tpp_row_s rows [8] = '{
      '{32'h00010001, 8'h32, 1'b0, 3'h1, 3'h0}, // Alarm at limit
      '{32'h00010001, 8'h31, 1'b0, 3'h0, 3'h0}, // One below
      '{32'h00000002, 8'h5A, 1'b0, 3'h2, 3'h2}, // Ninth channel off
      '{32'h00030003, 8'h64, 1'b1, 3'h4, 3'h4}, // Other group
      '{32'h00000005, 8'h50, 1'b1, 3'h1, 3'h0}, // One of two over
      '{32'h00010001, 8'h50, 1'b1, 3'h1, 3'h1}, // Two over
      '{32'h00000001, 8'h50, 1'b1, 3'h1, 3'h1}, // Lone probe
      '{32'h00020000, 8'hC8, 1'b0, 3'h2, 3'h2}}; // Module two
   tpp_core #(.DELAY_CYC(DLY)) u_tpp_core (.clock(clock), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .poll_req(poll_req), .poll_addr(poll_addr), .poll_ack(poll_ack),
      .poll_done(poll_done), .poll_temps(poll_temps), .alarm(alarm), .trip(trip));
   tpp_probe_model u_tpp_probe_model (.clock(clock), .reset(reset), .poll_req(poll_req),
      .poll_addr(poll_addr), .poll_ack(poll_ack), .poll_done(poll_done),
      .poll_temps(poll_temps), .temp_tab(temp_tab), .lag(lag), .clr(clr), .polled(polled));
   // Free-running clock
   always #5 clock = ~clock;
   // Hang guard: a run well past the planned length is a failure
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compared %0d, wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // One access; held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic set_hot(input logic [7:0] t);
      temp_tab[0] = {{7{8'h14}}, t};
      temp_tab[7] = {{7{8'h14}}, t};
   endtask : set_hot
   // Main sequence
   initial begin
      set_hot(8'h14);
      for (int i = 1; i < 7; i++) temp_tab[i] = 64'h0;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (300) @(posedge clock);
      chk({24'h0, polled}, 32'h0, "poll while off");
      bus(1'b0, REG_MOD_ADDR, 0); chk(rd, 32'h0, "addr reset");
      bus(1'b0, REG_ALARM_LIM, 0); chk(rd, RESET_LIMITS, "alarm lim reset");
      bus(1'b0, REG_TRIP_LIM, 0); chk(rd, RESET_LIMITS, "trip lim reset");
      bus(1'b0, REG_VOTE, 0); chk(rd, 32'h0, "vote reset");
      bus(1'b0, 8'h80, 0); chk(rd, BAD_READ, "unmapped");
      bus(1'b1, REG_ALARM_LIM, 32'h00C9FF00);
      bus(1'b0, REG_ALARM_LIM, 0); chk(rd, 32'h00C8C801, "clamp");
      $display("reset and limits test done");
      // Distinct addresses at both ends of the range
      bus(1'b1, REG_MOD_ADDR, 32'h00001710);
      bus(1'b1, REG_ALARM_LIM, 32'h00463C32);
      bus(1'b1, REG_TRIP_LIM, 32'h00645A50);
      foreach (rows[i]) begin
         lag <= 4'(i);
         set_hot(rows[i].t);
         bus(1'b1, REG_GROUP, rows[i].grp);
         bus(1'b1, REG_VOTE, {31'h0, rows[i].vote});
         repeat (1000) @(posedge clock);
         chk({29'h0, alarm}, {29'h0, rows[i].al}, "alarm");
         chk({29'h0, trip}, {29'h0, rows[i].tr}, "trip");
         bus(1'b0, REG_STATUS, 0); chk(rd, {25'h0, rows[i].tr, 1'b0, rows[i].al}, "status");
         bus(1'b0, REG_TEMP_BASE + 8'h20, 0); chk(rd, {24'h0, rows[i].t}, "ch9");
         $display("row %0d done", i);
      end
      // Delay from reading to trip
      set_hot(8'h14);
      bus(1'b1, REG_VOTE, 0);
      bus(1'b1, REG_GROUP, 32'h00000001);
      repeat (1000) @(posedge clock);
      temp_tab[0] = {{7{8'h14}}, 8'h50};
      n = 0;
      while (!(poll_done === 1'b1 && poll_temps[7:0] == 8'h50) && n < 1000) begin
         @(posedge clock);
         n++;
      end
      n = 0;
      while (trip[0] !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      chk(32'(n >= DLY && n <= DLY + 4), 32'h1, "trip delay");
      // Modules now differ, so a swapped channel slot shows
      bus(1'b0, REG_TEMP_BASE, 0); chk(rd, 32'h50, "ch1 slot");
      bus(1'b0, REG_TEMP_BASE + 8'h20, 0); chk(rd, 32'h14, "ch9 slot");
      $display("delay test done, %0d cycles", n);
      // Out-of-range second address turns that module off
      bus(1'b1, REG_MOD_ADDR, 32'h00001810);
      bus(1'b0, REG_MOD_ADDR, 0); chk(rd, 32'h00000010, "addr range");
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (800) @(posedge clock);
      chk({24'h0, polled}, 32'h01, "off module polled");
      $display("address off test done");
      // Reset in mid-run brings every setting back to its default
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk({26'h0, trip, alarm}, 32'h0, "outputs after reset");
      bus(1'b0, REG_MOD_ADDR, 0); chk(rd, 32'h0, "addr after reset");
      bus(1'b0, REG_GROUP, 0); chk(rd, 32'h0, "group after reset");
      // Only the stator byte lane is written
      avs_byteenable <= 4'h1;
      bus(1'b1, REG_ALARM_LIM, 32'h00010203);
      avs_byteenable <= 4'hF;
      bus(1'b0, REG_ALARM_LIM, 0); chk(rd, 32'h00C8C803, "lane write");
      $display("mid-run reset test done");
      print_verdict();
   end
endmodule : tpp_core_tb
